/* File: src/dob_pkg.sv */
// package: constants and types for the ddr2 calibration/termination block
// Operation
// - emr1 bits 9..7 pick exit, drive high, drive low, adjust, default
// - drive high sets dq/dqs/rdqs high; drive low sets them low
// - rdqs driven in drive modes only when its enable bit is set
// - adjust code steps pull-up and pull-down by one per table
// - one strength setting serves every dq driver together
// - step counters span 16 steps, saturate, start anywhere in range
// - adjust data taken at additive plus cas latency minus one
// - adjust beat order ignores sequential or interleaved burst type
// - calibration applies only with full drive strength selected
// - drive outputs switch on and off one tOIT after entry and exit
// - termination pin switches the leg chosen by nominal rtt
// - termination forced off during self refresh
// - new rtt takes effect within tMOD; cke held high meanwhile
// - activate is cs and ras low, cas and we high; bank and row
// - column command accepted the clock after activate, al 0 to 6
// - column command cs and cas low, ras high; we low writes
// - read latency is al plus cl; write latency one less
package dob_pkg;
  localparam int CLK_MHZ = 50;
  localparam int T_OIT_NS = 12;
  localparam int T_MOD_MAX_NS = 12;
  localparam int OIT_RAW = (T_OIT_NS * CLK_MHZ + 999) / 1000;
  localparam int TOIT_CYC = (OIT_RAW < 1) ? 1 : OIT_RAW;
  localparam int MOD_RAW = (T_MOD_MAX_NS * CLK_MHZ) / 1000;
  localparam int TMOD_CYC = (MOD_RAW < 1) ? 1 : MOD_RAW;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_STEP = 8'h08;
  localparam logic [7:0] REG_LAT = 8'h0C;
  localparam logic [7:0] REG_ODT = 8'h10;

  localparam int EMR_OCD_LSB = 7;
  localparam int EMR_RDQS_BIT = 11;
  localparam int EMR_HALF_BIT = 1;
  localparam int EMR_RTT_HI = 6;
  localparam int EMR_RTT_LO = 2;
  localparam int EMR_AL_LSB = 3;
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int PRE_ALL_BIT = 10;

  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DRV1 = 3'h1;
  localparam logic [2:0] OCD_DRV0 = 3'h2;
  localparam logic [2:0] OCD_ADJ = 3'h4;
  localparam logic [2:0] OCD_DFLT = 3'h7;

  localparam logic [3:0] STEP_RST = 4'h8;
  localparam logic [3:0] STEP_MAX = 4'hF;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] AL_RST = 3'h0;
  localparam logic [2:0] BL_RST = 3'h2;
  localparam logic CTRL_RST = 1'b1;

  typedef enum logic [1:0] {
    OCD_NORM = 2'b00,
    OCD_DRVH = 2'b01,
    OCD_DRVL = 2'b11,
    OCD_ADJS = 2'b10
  } dob_ocd_t;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD
  } dob_cmd_t;
endpackage

/* File: src/dob_step_if.sv */
// interface: step commands and settings between control and counters
`timescale 1ns/1ns
interface dob_step_if;
  logic [1:0] inc;
  logic [1:0] dec;
  logic load;
  logic [3:0] load_val;
  logic [1:0][3:0] step;
  modport ctl(output inc, output dec, output load, output load_val,
              input step);
  modport ctr(input inc, input dec, input load, input load_val,
              output step);
endinterface

/* File: src/dob_step_ctr.sv */
// module: saturating pull-up and pull-down impedance step counters
`timescale 1ns/1ns
module dob_step_ctr
  import dob_pkg::*;
(
  input wire logic pclk,    // system clock
  input wire logic presetn, // async reset, active low
  dob_step_if.ctr st        // step commands and settings
);
  // index 0 pull-up, index 1 pull-down
  for (genvar i = 0; i < 2; i++) begin : g_ctr
    logic [3:0] step_ff;
    wire up_ok = st.inc[i] && (step_ff != STEP_MAX);
    wire dn_ok = st.dec[i] && (step_ff != 4'h0);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        step_ff <= STEP_RST;
      end else if (st.load) begin
        step_ff <= st.load_val;
      end else if (up_ok) begin
        step_ff <= step_ff + 4'h1;
      end else if (dn_ok) begin
        step_ff <= step_ff - 4'h1;
      end
    end
    assign st.step[i] = step_ff;

    AST_STEP_SAT: assert property (@(posedge pclk) disable iff (!presetn)
      (!st.load && st.inc[i] && step_ff == STEP_MAX) |=>
        step_ff == STEP_MAX)
      else $error("step counter passed its top");
    AST_STEP_FLOOR: assert property (@(posedge pclk) disable iff (!presetn)
      (!st.load && !st.inc[i] && st.dec[i] && step_ff == 4'h0) |=>
        step_ff == 4'h0)
      else $error("step counter passed its floor");
  end
endmodule

/* File: src/dob_ddr2_dev.sv */
// module: ddr2 device calibration, termination and bank command logic
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module dob_ddr2_dev
  import dob_pkg::*;
(
  input wire logic pclk,              // system clock, 50 MHz
  input wire logic presetn,           // async reset, active low
  input wire logic psel,              // apb select
  input wire logic penable,           // apb enable
  input wire logic pwrite,            // apb write
  input wire logic [7:0] paddr,       // apb byte address
  input wire logic [31:0] pwdata,     // apb write data
  output logic [31:0] prdata,         // apb read data
  output logic pready,                // apb ready
  output logic pslverr,               // apb error, unmapped address
  input wire logic ck,                // link clock
  input wire logic cke,               // clock enable
  input wire logic cs_n,              // chip select, active low
  input wire logic ras_n,             // row strobe, active low
  input wire logic cas_n,             // column strobe, active low
  input wire logic we_n,              // write enable, active low
  input wire logic [1:0] ba,          // bank address
  input wire logic [13:0] addr,       // address
  input wire logic odt,               // termination control pin
  input wire logic [7:0] dq_i,        // data pins, input side
  output logic [7:0] dq_o,            // data pins, output side
  output logic dq_oe_n,               // data drive enable, active low
  output logic dqs_o,                 // strobe true output
  output logic dqs_c_o,               // strobe complement output
  output logic dqs_oe_n,              // strobe drive enable, active low
  output logic rdqs_o,                // read strobe true output
  output logic rdqs_c_o,              // read strobe complement output
  output logic rdqs_oe_n,             // read strobe enable, active low
  output logic [2:0] odt_leg,         // termination switch legs
  output logic [3:0] drv_pu_step,     // pull-up step for all dq
  output logic [3:0] drv_pd_step,     // pull-down step for all dq
  output logic drv_cal_ok,            // calibration in force
  output logic cmd_act,               // activate pulse
  output logic cmd_rd,                // read pulse
  output logic cmd_wr,                // write pulse
  output logic [1:0] cmd_bank,        // bank of last activate, read or write
  output logic [13:0] cmd_addr        // address of last activate, read or write
);
  function automatic dob_cmd_t cmd_dec(input logic c, r, a, w);
    if (c) return CMD_NOP;
    unique case ({r, a, w})
      3'b000: return CMD_MRS;
      3'b001: return CMD_REF;
      3'b010: return CMD_PRE;
      3'b011: return CMD_ACT;
      3'b100: return CMD_WR;
      3'b101: return CMD_RD;
      default: return CMD_NOP;
    endcase
  endfunction

  // returns {pu_inc, pu_dec, pd_inc, pd_dec}, code is {dt0..dt3}
  function automatic logic [3:0] adj_dec(input logic [3:0] c);
    unique case (c)
      4'h1: return 4'h8;
      4'h2: return 4'h4;
      4'h4: return 4'h2;
      4'h8: return 4'h1;
      4'h5: return 4'hA;
      4'h6: return 4'h6;
      4'h9: return 4'h9;
      4'hA: return 4'h5;
      default: return 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and link clock edges
  logic [30:0] pin_s1_ff;
  logic [30:0] pin_s2_ff;
  logic ck_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      ck_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq_i};
      pin_s2_ff <= pin_s1_ff;
      ck_prev_ff <= pin_s2_ff[30];
    end
  end
  wire s_ck = pin_s2_ff[30];
  wire s_cke = pin_s2_ff[29];
  wire [1:0] s_ba = pin_s2_ff[24:23];
  wire [13:0] s_a = pin_s2_ff[22:9];
  wire s_odt = pin_s2_ff[8];
  wire s_dq0 = pin_s2_ff[0];
  wire ck_rise = s_ck && !ck_prev_ff;
  wire ck_fall = !s_ck && ck_prev_ff;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  logic link_en_ff;
  logic self_ref_ff;
  wire dob_cmd_t cmd = cmd_dec(pin_s2_ff[28], pin_s2_ff[27],
                               pin_s2_ff[26], pin_s2_ff[25]);
  wire cmd_ok = ck_rise && s_cke && link_en_ff && !self_ref_ff;
  wire emr1_wr = cmd_ok && cmd == CMD_MRS && s_ba == 2'b01;
  wire mr_wr = cmd_ok && cmd == CMD_MRS && s_ba == 2'b00;
  wire [2:0] ocd_op = s_a[EMR_OCD_LSB+:3];
  wire sr_entry = ck_rise && link_en_ff && !s_cke && cmd == CMD_REF;
  wire sr_exit = ck_rise && self_ref_ff && s_cke;
  wire act_c = cmd_ok && cmd == CMD_ACT;
  wire pre_c = cmd_ok && cmd == CMD_PRE;
  wire col_c = cmd_ok && (cmd == CMD_RD || cmd == CMD_WR);

  ////////////////////////////////////////////////////////////////////////
  // mode fields and latencies
  logic [2:0] mr_bl_ff;
  logic [2:0] mr_cl_ff;
  logic [2:0] emr_al_ff;
  logic emr_rdqs_ff;
  logic emr_half_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_bl_ff <= BL_RST;
      mr_cl_ff <= CL_RST;
      emr_al_ff <= AL_RST;
      emr_rdqs_ff <= 1'b0;
      emr_half_ff <= 1'b0;
    end else if (mr_wr) begin
      mr_bl_ff <= s_a[MR_BL_LSB+:3];
      mr_cl_ff <= s_a[MR_CL_LSB+:3];
    end else if (emr1_wr) begin
      emr_al_ff <= s_a[EMR_AL_LSB+:3];
      emr_rdqs_ff <= s_a[EMR_RDQS_BIT];
      emr_half_ff <= s_a[EMR_HALF_BIT];
    end
  end
  wire [3:0] rl = {1'b0, emr_al_ff} + {1'b0, mr_cl_ff};
  wire [3:0] wl = rl - 4'h1;

  ////////////////////////////////////////////////////////////////////////
  // calibration mode and drive timing
  dob_ocd_t ocd_st_ff;
  dob_ocd_t nxt_ocd;
  always_comb begin
    nxt_ocd = ocd_st_ff;
    if (emr1_wr) begin
      unique case (ocd_op)
        OCD_DRV1: nxt_ocd = OCD_DRVH;
        OCD_DRV0: nxt_ocd = OCD_DRVL;
        OCD_ADJ: nxt_ocd = OCD_ADJS;
        OCD_EXIT, OCD_DFLT: nxt_ocd = OCD_NORM;
        default: nxt_ocd = ocd_st_ff;
      endcase
    end
  end
  wire in_drv = ocd_st_ff == OCD_DRVH || ocd_st_ff == OCD_DRVL;
  wire drv_entry = emr1_wr && (ocd_op == OCD_DRV1 || ocd_op == OCD_DRV0);
  wire drv_exit = emr1_wr && ocd_op == OCD_EXIT && in_drv;

  logic [2:0] oit_cnt_ff;
  logic drv_tgt_ff;
  logic drv_on_ff;
  logic drv_hi_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocd_st_ff <= OCD_NORM;
      oit_cnt_ff <= 3'h0;
      drv_tgt_ff <= 1'b0;
      drv_on_ff <= 1'b0;
      drv_hi_ff <= 1'b0;
    end else begin
      ocd_st_ff <= nxt_ocd;
      if (drv_entry || drv_exit) begin
        oit_cnt_ff <= 3'(TOIT_CYC);
        drv_tgt_ff <= drv_entry;
        if (drv_entry) drv_hi_ff <= ocd_op == OCD_DRV1;
      end else if (oit_cnt_ff != 3'h0) begin
        oit_cnt_ff <= oit_cnt_ff - 3'h1;
        if (oit_cnt_ff == 3'h1) drv_on_ff <= drv_tgt_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // adjust code capture, one dq serves since all carry the same code
  logic [3:0] adj_cnt_ff;
  logic [1:0] beat_ff;
  logic cap_busy_ff;
  logic [3:0] code_ff;
  logic adj_fire_ff;
  wire adj_cmd = emr1_wr && ocd_op == OCD_ADJ;
  wire cap_start = ck_rise && adj_cnt_ff == 4'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adj_cnt_ff <= 4'h0;
      beat_ff <= 2'h0;
      cap_busy_ff <= 1'b0;
      code_ff <= 4'h0;
      adj_fire_ff <= 1'b0;
    end else begin
      adj_fire_ff <= 1'b0;
      if (adj_cmd) begin
        adj_cnt_ff <= wl;
      end else if (ck_rise && adj_cnt_ff != 4'h0) begin
        adj_cnt_ff <= adj_cnt_ff - 4'h1;
      end
      if (cap_start) begin
        code_ff <= {s_dq0, 3'h0};
        beat_ff <= 2'h1;
        cap_busy_ff <= 1'b1;
      end else if (cap_busy_ff && (ck_rise || ck_fall)) begin
        code_ff[2'h3 - beat_ff] <= s_dq0;
        beat_ff <= beat_ff + 2'h1;
        if (beat_ff == 2'h3) begin
          cap_busy_ff <= 1'b0;
          adj_fire_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // step counters, shared by every dq driver
  logic [3:0] step_init_ff;
  dob_step_if step_bus();
  wire [3:0] adj_op = adj_fire_ff ? adj_dec(code_ff) : 4'h0;
  assign step_bus.inc = {adj_op[1], adj_op[3]};
  assign step_bus.dec = {adj_op[0], adj_op[2]};
  assign step_bus.load = emr1_wr && ocd_op == OCD_DFLT;
  assign step_bus.load_val = step_init_ff;
  dob_step_ctr u_step (
    .pclk(pclk),
    .presetn(presetn),
    .st(step_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // termination, self refresh and banks
  logic [1:0] rtt_pend_ff;
  logic [1:0] rtt_act_ff;
  logic [2:0] mod_cnt_ff;
  logic [3:0] bank_open_ff;
  logic [2:0] err_ff;
  wire [2:0] leg_w = {rtt_act_ff == 2'h3, rtt_act_ff == 2'h2,
                      rtt_act_ff == 2'h1};
  wire [2:0] err_set = {mod_cnt_ff != 3'h0 && !s_cke,
                        act_c && bank_open_ff[s_ba],
                        col_c && !bank_open_ff[s_ba]};
  wire [2:0] err_clr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtt_pend_ff <= 2'h0;
      rtt_act_ff <= 2'h0;
      mod_cnt_ff <= 3'h0;
      self_ref_ff <= 1'b0;
      bank_open_ff <= 4'h0;
      err_ff <= 3'h0;
    end else begin
      if (emr1_wr) begin
        rtt_pend_ff <= {s_a[EMR_RTT_HI], s_a[EMR_RTT_LO]};
        mod_cnt_ff <= 3'(TMOD_CYC);
      end else if (mod_cnt_ff != 3'h0) begin
        mod_cnt_ff <= mod_cnt_ff - 3'h1;
        if (mod_cnt_ff == 3'h1) rtt_act_ff <= rtt_pend_ff;
      end
      if (sr_entry) self_ref_ff <= 1'b1;
      else if (sr_exit) self_ref_ff <= 1'b0;
      if (act_c) bank_open_ff[s_ba] <= 1'b1;
      else if (pre_c && s_a[PRE_ALL_BIT]) bank_open_ff <= 4'h0;
      else if (pre_c) bank_open_ff[s_ba] <= 1'b0;
      err_ff <= (err_ff & ~err_clr) | err_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin and side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_o <= 8'h00;
      dq_oe_n <= 1'b1;
      dqs_o <= 1'b0;
      dqs_c_o <= 1'b1;
      dqs_oe_n <= 1'b1;
      rdqs_o <= 1'b0;
      rdqs_c_o <= 1'b1;
      rdqs_oe_n <= 1'b1;
      odt_leg <= 3'h0;
      drv_pu_step <= STEP_RST;
      drv_pd_step <= STEP_RST;
      drv_cal_ok <= 1'b0;
      cmd_act <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_wr <= 1'b0;
      cmd_bank <= 2'h0;
      cmd_addr <= 14'h0000;
    end else begin
      dq_o <= {8{drv_hi_ff}};
      dq_oe_n <= !drv_on_ff;
      dqs_o <= drv_hi_ff;
      dqs_c_o <= !drv_hi_ff;
      dqs_oe_n <= !drv_on_ff;
      rdqs_o <= drv_hi_ff;
      rdqs_c_o <= !drv_hi_ff;
      rdqs_oe_n <= !(drv_on_ff && emr_rdqs_ff);
      odt_leg <= (s_odt && !self_ref_ff) ? leg_w : 3'h0;
      drv_pu_step <= step_bus.step[0];
      drv_pd_step <= step_bus.step[1];
      drv_cal_ok <= !emr_half_ff;
      cmd_act <= act_c;
      cmd_rd <= cmd_ok && cmd == CMD_RD;
      cmd_wr <= cmd_ok && cmd == CMD_WR;
      if (act_c || col_c) begin
        cmd_bank <= s_ba;
        cmd_addr <= s_a;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire hit_ctrl = paddr == REG_CTRL;
  wire hit_stat = paddr == REG_STAT;
  wire hit_step = paddr == REG_STEP;
  wire hit_lat = paddr == REG_LAT;
  wire hit_odt = paddr == REG_ODT;
  wire hit = hit_ctrl | hit_stat | hit_step | hit_lat | hit_odt;
  assign err_clr = (wr_acc && hit_stat) ? pwdata[10:8] : 3'h0;
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0000_0000, link_en_ff} :
    hit_stat ? {21'h00_0000, err_ff, bank_open_ff, self_ref_ff,
                drv_on_ff, ocd_st_ff} :
    hit_step ? {20'h0_0000, step_init_ff, step_bus.step[1],
                step_bus.step[0]} :
    hit_lat ? {12'h000, wl, rl, 1'b0, emr_al_ff, 1'b0, mr_cl_ff,
               1'b0, mr_bl_ff} :
    hit_odt ? {25'h000_0000, odt_leg, rtt_pend_ff, rtt_act_ff} :
    32'h0000_0000;
  logic [31:0] prdata_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      link_en_ff <= CTRL_RST;
      step_init_ff <= STEP_RST;
    end else begin
      if (setup) prdata_ff <= rd_mux;
      if (wr_acc && hit_ctrl) link_en_ff <= pwdata[0];
      if (wr_acc && hit_step) step_init_ff <= pwdata[11:8];
    end
  end
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////
  // checks
  localparam int OIT_D = TOIT_CYC + 1; // counter load edge
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OCD_DECODE: assert property (emr1_wr && ocd_op == OCD_DRV0 |=>
    ocd_st_ff == OCD_DRVL)
    else $error("drive low code not decoded");
  AST_DRIVE_LEVEL: assert property (drv_on_ff && !drv_hi_ff |=>
    dq_o == 8'h00 && !dqs_o && dqs_c_o && !dq_oe_n)
    else $error("drive low levels wrong");
  AST_RDQS_GATE: assert property (!emr_rdqs_ff |=> rdqs_oe_n)
    else $error("rdqs driven while disabled");
  AST_ADJ_PU: assert property (adj_fire_ff && code_ff == 4'h1 &&
    step_bus.step[0] != STEP_MAX |=>
      step_bus.step[0] == 4'($past(step_bus.step[0]) + 4'h1))
    else $error("pull-up step not raised");
  AST_CAP_LAT: assert property (adj_cmd ##1 (!ck_rise [*3]) |->
    adj_cnt_ff == $past(wl, 4))
    else $error("adjust latency not loaded");
  AST_OIT: assert property (drv_entry |-> ##OIT_D drv_on_ff)
    else $error("drive not on after toit");
  AST_SR_ODT: assert property (self_ref_ff |=> odt_leg == 3'h0)
    else $error("termination on in self refresh");
  AST_RTT_UPD: assert property (mod_cnt_ff == 3'h1 && !emr1_wr |=>
    rtt_act_ff == $past(rtt_pend_ff))
    else $error("rtt not updated at end of window");
  AST_ACT_OPEN: assert property (act_c |=> bank_open_ff[$past(s_ba)]
    && cmd_act ##1 !cmd_act)
    else $error("activated bank not open");
  COV_DRIVE: cover property (drv_entry ##[1:300] drv_exit);
  COV_ADJ: cover property (adj_fire_ff && adj_op != 4'h0);
  COV_SR: cover property (sr_entry ##[1:1000] sr_exit);
endmodule

/* File: verif/dob_ctl_model.sv */
// model: controller side of the ddr2 link, command and data pins
`timescale 1ns/1ns
module dob_ctl_model
  import dob_pkg::*;
(
  output logic ck,          // link clock, runs free
  output logic cke,         // clock enable
  output logic [3:0] cmd_n, // cs, ras, cas, we, active low
  output logic [1:0] ba,    // bank address
  output logic [13:0] addr, // address
  output logic odt,         // termination pin
  output logic [7:0] dq     // data toward the device
);
  initial begin
    cke = 1'b1;
    cmd_n = 4'hF;
    ba = 2'b00;
    addr = 14'h0000;
    odt = 1'b0;
    dq = 8'h00;
  end
  initial begin
    ck = 1'b0;
    #7;
    forever #80 ck = ~ck;
  end
  //////////////////////////////////////////////////////////////////////
  // one command at a rise, then a no-op; released lines invert
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [13:0] a);
    @(negedge ck);
    cmd_n <= c;
    ba <= b;
    addr <= a;
    @(negedge ck);
    cmd_n <= 4'h7;
    ba <= ~b;
    addr <= ~a;
  endtask
  // adjust burst: one code on every dq, dt0 first, mid-phase changes
  task automatic adjust(input logic [3:0] code, input logic [13:0] a,
                        input int wl);
    cmd(4'h0, 2'b01, a);
    repeat (wl - 1) @(negedge ck);
    #40 dq <= {8{code[3]}};
    @(posedge ck);
    #40 dq <= {8{code[2]}};
    @(negedge ck);
    #40 dq <= {8{code[1]}};
    @(posedge ck);
    #40 dq <= {8{code[0]}};
    @(negedge ck);
    #40 dq <= ~dq;
  endtask
endmodule

/* File: verif/test_ddr2_ocd_odt_bank_access.sv */
// testbench: calibration, termination and bank commands against a model
`timescale 1ns/1ns
module test_ddr2_ocd_odt_bank_access;
  import dob_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ck, cke, odt, dq_oe_n, dqs_o, dqs_c_o;
  logic dqs_oe_n, rdqs_o, rdqs_c_o, rdqs_oe_n, drv_cal_ok;
  logic cmd_act, cmd_rd, cmd_wr;
  logic [3:0] cmd_n, drv_pu_step, drv_pd_step, code;
  logic [1:0] ba, cmd_bank;
  logic [13:0] addr, cmd_addr, row;
  logic [7:0] dq_i, dq_o;
  logic [2:0] odt_leg;
  logic [3:0] tbl [12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6,
                           4'h9, 4'hA, 4'h3, 4'hF, 4'hC};
  int errors = 0;
  int samples_checked = 0;
  int seed = 32238;
  int pu = 5;
  int pd = 5;
  int hits [3] = '{0, 0, 0};
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    hits[0] <= hits[0] + int'(cmd_act === 1'b1);
    hits[1] <= hits[1] + int'(cmd_rd === 1'b1);
    hits[2] <= hits[2] + int'(cmd_wr === 1'b1);
  end
  dob_ddr2_dev DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ck, .cke, .cs_n(cmd_n[3]),
    .ras_n(cmd_n[2]), .cas_n(cmd_n[1]), .we_n(cmd_n[0]), .ba, .addr, .odt,
    .dq_i, .dq_o, .dq_oe_n, .dqs_o, .dqs_c_o, .dqs_oe_n, .rdqs_o,
    .rdqs_c_o, .rdqs_oe_n, .odt_leg, .drv_pu_step, .drv_pd_step,
    .drv_cal_ok, .cmd_act, .cmd_rd, .cmd_wr, .cmd_bank, .cmd_addr);
  dob_ctl_model ctl (.ck, .cke, .cmd_n, .ba, .addr, .odt, .dq(dq_i));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle();
    repeat (24) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog, about fourteen times the expected run
  initial begin
    #1_500_000;
    errors++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, REG_STEP, 32'h0000_0500, rd);
    apb(1'b0, REG_STEP, 32'h0000_0000, rd);
    check(rd[11:8], 32'h0000_0005);
    apb(1'b0, 8'h40, 32'h0000_0000, rd);
    check({err, rd[30:0]}, 32'h8000_0000);
    ctl.cmd(4'h0, 2'b00, 14'h0032);
    ctl.cmd(4'h0, 2'b01, 14'h0388);
    ctl.cmd(4'h0, 2'b01, 14'h0008);
    settle();
    apb(1'b0, REG_LAT, 32'h0000_0000, rd);
    check(rd[19:8], 32'h0000_0341);
    for (int i = 0; i < 52; i++) begin
      code = i < 12 ? tbl[i] : i < 22 ? 4'h5 : i < 40 ? 4'hA :
             tbl[{$random(seed)} % 12];
      if (code inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9,
                       4'hA}) begin
        pu = pu + int'(code[0]) - int'(code[1]);
        pd = pd + int'(code[2]) - int'(code[3]);
      end
      pu = pu > 15 ? 15 : (pu < 0 ? 0 : pu);
      pd = pd > 15 ? 15 : (pd < 0 ? 0 : pd);
      if (i == 26) ctl.cmd(4'h0, 2'b00, 14'h003A);
      ctl.adjust(code, 14'h0208, 3);
      ctl.cmd(4'h0, 2'b01, 14'h0008);
      settle();
      check(drv_pu_step, pu);
      check(drv_pd_step, pd);
    end
    ctl.cmd(4'h0, 2'b01, 14'h0888);
    settle();
    check({dq_o, dq_oe_n, dqs_o, dqs_c_o, dqs_oe_n, rdqs_o, rdqs_c_o,
           rdqs_oe_n}, {8'hFF, 7'h24});
    ctl.cmd(4'h0, 2'b01, 14'h0008);
    settle();
    check({dq_oe_n, dqs_oe_n, rdqs_oe_n}, 3'h7);
    check({drv_pu_step, drv_pd_step}, {pu[3:0], pd[3:0]});
    ctl.cmd(4'h0, 2'b01, 14'h0108);
    settle();
    check({dq_o, dq_oe_n, dqs_o, dqs_c_o, dqs_oe_n, rdqs_oe_n},
          {8'h00, 5'h05});
    ctl.cmd(4'h0, 2'b01, 14'h000A);
    settle();
    check(drv_cal_ok, 1'b0);
    ctl.cmd(4'h0, 2'b01, 14'h0008);
    settle();
    check({dq_oe_n, drv_cal_ok}, 2'h3);
    for (int r = 1; r < 4; r++) begin
      ctl.cmd(4'h0, 2'b01, {7'h00, r[1], 3'h1, r[0], 2'h0});
      settle();
      ctl.odt <= 1'b1;
      settle();
      check(odt_leg, 3'h1 << (r - 1));
      ctl.odt <= 1'b0;
    end
    ctl.cke <= 1'b0;
    ctl.cmd(4'h1, 2'b00, 14'h0000);
    ctl.odt <= 1'b1;
    settle();
    check(odt_leg, 3'h0);
    ctl.cke <= 1'b1;
    settle();
    check(odt_leg, 3'h4);
    ctl.odt <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      row = 14'($random(seed));
      ctl.cmd(4'h3, b[1:0], row);
      settle();
      check({cmd_bank, cmd_addr}, {b[1:0], row});
      ctl.cmd(4'h5, b[1:0], row & 14'h03FF);
      ctl.cmd(4'h4, b[1:0], 14'h0008);
      settle();
      check({cmd_bank, cmd_addr}, {b[1:0], 14'h0008});
      ctl.cmd(4'h2, b[1:0], 14'h0000);
    end
    check(hits[1], 4);
    check(hits[2], 4);
    apb(1'b1, REG_CTRL, 32'h0000_0000, rd);
    ctl.cmd(4'h3, 2'b00, 14'h0000);
    settle();
    check(hits[0], 4);
    apb(1'b1, REG_CTRL, 32'h0000_0001, rd);
    ctl.cmd(4'h3, 2'b00, 14'h0000);
    settle();
    check(hits[0], 5);
    ctl.cmd(4'h3, 2'b11, 14'h0000);
    settle();
    apb(1'b0, REG_STAT, 32'h0000_0000, rd);
    check(rd[10:0], 32'h0000_0090);
    ctl.cmd(4'h2, 2'b10, 14'h0400);
    settle();
    apb(1'b0, REG_STAT, 32'h0000_0000, rd);
    check(rd[10:0], 32'h0000_0000);
    give_verdict();
  end
endmodule
